// >>> shared/fsecc_pkg.sv
// Constants and types of the frame sync and ECC block.
package fsecc_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int MEM_W = 32;
	localparam int CODE_W = 39;
	localparam int MEM_DEPTH = 16;
	localparam int MEM_AW = 4;
	localparam int CNT_W = 16;
	localparam int LINE_W = 16;

	localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] REG_SYNC_CMD = 4'h1;
	localparam logic [ADDR_W-1:0] REG_ACTIVE_LINES = 4'h2;
	localparam logic [ADDR_W-1:0] REG_MIN_BLANK = 4'h3;
	localparam logic [ADDR_W-1:0] REG_SYNC_DELAY = 4'h4;
	localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 4'h5;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'h6;
	localparam logic [ADDR_W-1:0] REG_ECC_STATUS = 4'h7;
	localparam logic [ADDR_W-1:0] REG_STATUS_LINE = 4'h8;

	localparam int CTRL_FMP_BIT = 0;
	localparam int CTRL_STREAM_BIT = 1;
	localparam int IRQ_W = 4;
	localparam int IRQ_SYNC = 0;
	localparam int IRQ_FSTART = 1;
	localparam int IRQ_SEC = 2;
	localparam int IRQ_DED = 3;

	localparam logic [LINE_W-1:0] ACTIVE_LINES_RST = 16'h03d4;
	localparam logic [LINE_W-1:0] MIN_BLANK_RST = 16'h0010;
	localparam logic [LINE_W-1:0] LINE_CLKS = 16'h0100;

	typedef enum logic [1:0] {
		FSECC_ST_IDLE = 2'b00,
		FSECC_ST_ACTIVE = 2'b01,
		FSECC_ST_BLANK = 2'b10
	} fsecc_state_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} fsecc_bus_t;

	typedef struct packed {
		logic [MEM_AW-1:0] addr;
		logic [MEM_W-1:0] wdata;
		logic wr;
		logic rd;
	} fsecc_mem_req_t;
endpackage

// >>> verilog/fsecc_secded.sv
// Hamming single-correct double-detect encoder and decoder.
`timescale 1ns/10ps
module fsecc_secded
	import fsecc_pkg::*;
(
	input wire logic [fsecc_pkg::MEM_W-1:0] data_i,
	output logic [fsecc_pkg::CODE_W-1:0] code_o,
	input wire logic [fsecc_pkg::CODE_W-1:0] code_i,
	output logic [fsecc_pkg::MEM_W-1:0] fixed_o,
	output logic single_o,
	output logic double_o
);
	// Code bit 0 is overall parity, bits 1..38 a Hamming code.
	function automatic logic [CODE_W-1:0] encode(
		input logic [MEM_W-1:0] d);
		logic [CODE_W-1:0] c;
		int k;
		c = '0;
		k = 0;
		for (int p = 1; p < CODE_W; p++) begin
			if ((p & (p - 1)) != 0) begin
				c[p] = d[k];
				k++;
			end
		end
		for (int b = 0; b < 6; b++) begin
			for (int p = 1; p < CODE_W; p++) begin
				if (((p >> b) & 1) == 1 && p != (1 << b)) begin
					c[1 << b] = c[1 << b] ^ c[p];
				end
			end
		end
		c[0] = ^c[CODE_W-1:1];
		return c;
	endfunction

	logic [5:0] syn;
	logic par;
	logic [CODE_W-1:0] corr;

	always_comb begin
		code_o = encode(data_i);
	end

	always_comb begin
		syn = '0;
		for (int p = 1; p < CODE_W; p++) begin
			if (code_i[p]) begin
				syn = syn ^ p[5:0];
			end
		end
		par = ^code_i;
		corr = code_i;
		if (syn != 6'h00 && par && int'(syn) < CODE_W) begin
			corr[syn] = ~corr[syn];
		end
		fixed_o = '0;
		for (int p = 1, k = 0; p < CODE_W; p++) begin
			if ((p & (p - 1)) != 0) begin
				fixed_o[k] = corr[p];
				k++;
			end
		end
		single_o = par;
		double_o = !par && syn != 6'h00;
	end
endmodule

// >>> verilog/fsecc_top.sv
// Frame sync retiming and ECC-protected microcontroller SRAM.
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
module fsecc_top (
	input wire logic MCLK_I,
	input wire logic SYS_RST_I,
	input wire fsecc_pkg::fsecc_bus_t BUS_I,
	output logic [fsecc_pkg::DATA_W-1:0] RDATA_O,
	input wire logic FRAME_SYNC_INPUT_I,
	output logic INTEGRATION_START_OUTPUT_O,
	output logic FRAME_ACTIVE_O,
	output logic FAST_PLUS_O,
	input wire fsecc_pkg::fsecc_mem_req_t MEM_I,
	output logic [fsecc_pkg::MEM_W-1:0] MEM_RDATA_O,
	output logic MEM_RVALID_O,
	input wire logic [fsecc_pkg::CODE_W-1:0] MEM_FLIP_I,
	output logic ECC_ERROR_OUTPUT_O,
	output logic IRQ_O
);
	import fsecc_pkg::*;

	logic [DATA_W-1:0] ctrl_q;
	logic [LINE_W-1:0] active_lines_q;
	logic [LINE_W-1:0] min_blank_q;
	logic [IRQ_W-1:0] irq_mask_q;
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_ev;
	logic pin_q;
	logic sync_ev;
	logic sync_pend_q;
	logic [LINE_W-1:0] blank_target_q;
	fsecc_state_t state_q;
	logic [LINE_W-1:0] line_q;
	logic [LINE_W-1:0] clk_q;
	logic line_end;
	logic frame_start;
	logic meas_run_q;
	logic [DATA_W-1:0] meas_cnt_q;
	logic [DATA_W-1:0] sync_delay_q;
	logic int_out_q;
	logic [CODE_W-1:0] mem_q [MEM_DEPTH];
	logic [CODE_W-1:0] enc_code;
	logic [CODE_W-1:0] rd_code;
	logic [MEM_W-1:0] fixed;
	logic sec;
	logic ded;
	logic rd_chk_q;
	logic [MEM_AW-1:0] rd_addr_q;
	logic [CNT_W-1:0] sec_cnt_q;
	logic sec_flag_q;
	logic ded_flag_q;
	logic ecc_pin_q;
	logic [DATA_W-1:0] rdata_q;

	// Software registers; the bus defaults to Fast mode after reset.
	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I) begin
			ctrl_q <= '0;
			active_lines_q <= ACTIVE_LINES_RST;
			min_blank_q <= MIN_BLANK_RST;
			irq_mask_q <= '0;
		end else if (BUS_I.wr) begin
			unique case (BUS_I.addr)
				REG_CTRL: ctrl_q <= BUS_I.wdata;
				REG_ACTIVE_LINES: active_lines_q <= BUS_I.wdata[LINE_W-1:0];
				REG_MIN_BLANK: min_blank_q <= BUS_I.wdata[LINE_W-1:0];
				REG_IRQ_MASK: irq_mask_q <= BUS_I.wdata[IRQ_W-1:0];
				default: ;
			endcase
		end
	end
	assign FAST_PLUS_O = ctrl_q[CTRL_FMP_BIT];

	// Sync source: rising pin edge or a command write.
	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I) begin
			pin_q <= 1'b0;
		end else begin
			pin_q <= FRAME_SYNC_INPUT_I;
		end
	end
	assign sync_ev = (FRAME_SYNC_INPUT_I && !pin_q)
		|| (BUS_I.wr && BUS_I.addr == REG_SYNC_CMD);

	// Frame timing: line counter within active and blanking regions.
	assign line_end = clk_q == LINE_CLKS - 16'h0001;
	assign frame_start = line_end
		&& ((state_q == FSECC_ST_BLANK && line_q >= blank_target_q)
		|| (state_q == FSECC_ST_IDLE && ctrl_q[CTRL_STREAM_BIT]));

	// The line timer runs in idle once streaming is on, so the first
	// frame can start at a line boundary.
	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I || line_end
			|| (state_q == FSECC_ST_IDLE && !ctrl_q[CTRL_STREAM_BIT])) begin
			clk_q <= '0;
		end else begin
			clk_q <= clk_q + 16'h0001;
		end
	end

	// A pending sync never cuts the active region; it only shortens or
	// stretches the following blanking, so no frame is damaged.
	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I) begin
			state_q <= FSECC_ST_IDLE;
			line_q <= '0;
			sync_pend_q <= 1'b0;
			blank_target_q <= MIN_BLANK_RST;
		end else begin
			if (sync_ev) begin
				sync_pend_q <= 1'b1;
			end
			unique case (state_q)
				FSECC_ST_IDLE: begin
					if (frame_start) begin
						state_q <= FSECC_ST_ACTIVE;
						line_q <= '0;
					end
				end
				FSECC_ST_ACTIVE: begin
					if (line_end) begin
						line_q <= line_q + 16'h0001;
						if (line_q == active_lines_q - 16'h0001) begin
							state_q <= FSECC_ST_BLANK;
							line_q <= '0;
							// Pending sync: restart with least blanking.
							blank_target_q <= (sync_pend_q || sync_ev)
								? min_blank_q - 16'h0001
								: blank_target_q;
						end
					end
				end
				FSECC_ST_BLANK: begin
					if (line_end) begin
						line_q <= line_q + 16'h0001;
					end
					if (sync_ev && line_q + 16'h0001 >= min_blank_q) begin
						blank_target_q <= line_q;
					end
					if (frame_start) begin
						state_q <= FSECC_ST_ACTIVE;
						line_q <= '0;
						// A sync in the start cycle stays pending.
						sync_pend_q <= sync_ev;
					end
				end
				default: state_q <= FSECC_ST_IDLE;
			endcase
		end
	end
	assign FRAME_ACTIVE_O = state_q == FSECC_ST_ACTIVE;

	// Delay from the latest sync event to the next frame start; a sync in a cycle that stores a delay is not timed.
	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I) begin
			meas_run_q <= 1'b0;
			meas_cnt_q <= '0;
			sync_delay_q <= '0;
		end else if (frame_start && meas_run_q) begin
			sync_delay_q <= meas_cnt_q;
			meas_run_q <= 1'b0;
		end else if (sync_ev) begin
			meas_run_q <= 1'b1;
			meas_cnt_q <= 32'h0000_0001;
		end else if (meas_run_q) begin
			meas_cnt_q <= meas_cnt_q + 32'h0000_0001;
		end
	end

	// Output rises as integration of a frame begins.
	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I) begin
			int_out_q <= 1'b0;
		end else if (frame_start) begin
			int_out_q <= 1'b1;
		end else if (line_end) begin
			int_out_q <= 1'b0;
		end
	end
	assign INTEGRATION_START_OUTPUT_O = int_out_q;

	// ECC protected storage; MEM_FLIP_I injects faults for test.
	fsecc_secded u_ecc (
		.data_i(MEM_I.wdata),
		.code_o(enc_code),
		.code_i(rd_code),
		.fixed_o(fixed),
		.single_o(sec),
		.double_o(ded)
	);

	always_ff @(posedge MCLK_I) begin
		if (MEM_I.wr) begin
			mem_q[MEM_I.addr] <= enc_code ^ MEM_FLIP_I;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I) begin
			rd_chk_q <= 1'b0;
			rd_addr_q <= '0;
		end else begin
			rd_chk_q <= MEM_I.rd;
			rd_addr_q <= MEM_I.addr;
		end
	end
	assign rd_code = mem_q[rd_addr_q];
	assign MEM_RVALID_O = rd_chk_q;

	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I) begin
			MEM_RDATA_O <= '0;
		end else if (rd_chk_q) begin
			MEM_RDATA_O <= fixed;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I) begin
			sec_cnt_q <= '0;
			sec_flag_q <= 1'b0;
		end else if (rd_chk_q && sec) begin
			sec_cnt_q <= sec_cnt_q + 16'h0001;
			sec_flag_q <= 1'b1;
		end
	end

	// Sticky until reset; software has no way to clear it.
	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I) begin
			ded_flag_q <= 1'b0;
			ecc_pin_q <= 1'b0;
		end else if (rd_chk_q && ded) begin
			ded_flag_q <= 1'b1;
			ecc_pin_q <= 1'b1;
		end
	end
	assign ECC_ERROR_OUTPUT_O = ecc_pin_q;

	// Interrupt status: set wins over the read clear.
	assign irq_ev = {rd_chk_q && ded, rd_chk_q && sec, frame_start, sync_ev};
	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I) begin
			irq_stat_q <= '0;
		end else if (BUS_I.rd && BUS_I.addr == REG_IRQ_STATUS) begin
			irq_stat_q <= irq_ev;
		end else begin
			irq_stat_q <= irq_stat_q | irq_ev;
		end
	end
	assign IRQ_O = |(irq_stat_q & irq_mask_q);

	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I) begin
			rdata_q <= '0;
		end else if (BUS_I.rd) begin
			unique case (BUS_I.addr)
				REG_CTRL: rdata_q <= ctrl_q;
				REG_ACTIVE_LINES: rdata_q <= {16'h0000, active_lines_q};
				REG_MIN_BLANK: rdata_q <= {16'h0000, min_blank_q};
				REG_SYNC_DELAY: rdata_q <= sync_delay_q;
				REG_IRQ_STATUS: rdata_q <= {28'h0000000, irq_stat_q};
				REG_IRQ_MASK: rdata_q <= {28'h0000000, irq_mask_q};
				REG_ECC_STATUS: rdata_q <= {14'h0000, ded_flag_q, sec_flag_q,
					sec_cnt_q};
				REG_STATUS_LINE: rdata_q <= {sec_cnt_q, 14'h0000, ded_flag_q,
					sec_flag_q};
				default: rdata_q <= '0;
			endcase
		end else begin
			rdata_q <= '0;
		end
	end
	assign RDATA_O = rdata_q;

	// Steps of the frame and memory error behaviours.
	sequence fsecc_active_last;
		state_q == FSECC_ST_ACTIVE && line_end
		&& line_q == active_lines_q - 16'h0001;
	endsequence
	sequence fsecc_sec_seen;
		rd_chk_q && sec;
	endsequence
	sequence fsecc_sec_logged;
		sec_flag_q && irq_stat_q[IRQ_SEC];
	endsequence
	sequence fsecc_ded_seen;
		rd_chk_q && ded;
	endsequence
	sequence fsecc_ded_latched;
		ECC_ERROR_OUTPUT_O && ded_flag_q && irq_stat_q[IRQ_DED];
	endsequence

	chk_pin_sync_edge: assert property (
		@(posedge MCLK_I) disable iff (SYS_RST_I)
		(!FRAME_SYNC_INPUT_I && pin_q && !BUS_I.wr) |-> !sync_ev)
		else $error("Falling pin edge made a sync event.");
	chk_cmd_sync: assert property (
		@(posedge MCLK_I) disable iff (SYS_RST_I)
		(BUS_I.wr && BUS_I.addr == REG_SYNC_CMD) |=>
		sync_pend_q || FRAME_ACTIVE_O == 1'b0)
		else $error("Sync command not taken.");
	chk_delay_stored: assert property (
		@(posedge MCLK_I) disable iff (SYS_RST_I)
		(frame_start && meas_run_q) |=> sync_delay_q == $past(meas_cnt_q))
		else $error("Sync delay not stored.");
	chk_active_full: assert property (
		@(posedge MCLK_I) disable iff (SYS_RST_I)
		(state_q == FSECC_ST_ACTIVE && line_q < active_lines_q - 16'h0001)
		|=> state_q == FSECC_ST_ACTIVE)
		else $error("Active frame cut short.");
	chk_blank_least: assert property (
		@(posedge MCLK_I) disable iff (SYS_RST_I)
		(fsecc_active_last ##0 sync_pend_q) |=>
		state_q == FSECC_ST_BLANK && blank_target_q == min_blank_q - 16'h0001)
		else $error("Pending sync did not select least blanking.");
	chk_integ_rise: assert property (
		@(posedge MCLK_I) disable iff (SYS_RST_I)
		frame_start |=> $rose(INTEGRATION_START_OUTPUT_O))
		else $error("No integration start edge.");
	chk_integ_active: assert property (
		@(posedge MCLK_I) disable iff (SYS_RST_I)
		$rose(INTEGRATION_START_OUTPUT_O) |-> FRAME_ACTIVE_O && line_q == '0)
		else $error("Integration edge away from frame start.");
	chk_sec_count: assert property (
		@(posedge MCLK_I) disable iff (SYS_RST_I)
		fsecc_sec_seen |=> sec_cnt_q == $past(sec_cnt_q) + 16'h0001)
		else $error("Single error not counted.");
	chk_sec_flag: assert property (
		@(posedge MCLK_I) disable iff (SYS_RST_I)
		fsecc_sec_seen |=> fsecc_sec_logged)
		else $error("Single error not flagged.");
	chk_ded_latch: assert property (
		@(posedge MCLK_I) disable iff (SYS_RST_I)
		fsecc_ded_seen |=> ECC_ERROR_OUTPUT_O [*3])
		else $error("Error pin not latched.");
	chk_ded_raise: assert property (
		@(posedge MCLK_I) disable iff (SYS_RST_I)
		fsecc_ded_seen |=> fsecc_ded_latched)
		else $error("Double error not flagged and raised.");
	chk_ded_hold: assert property (
		@(posedge MCLK_I) disable iff (SYS_RST_I)
		ded_flag_q |=> ded_flag_q)
		else $error("Uncorrectable flag cleared without reset.");
	chk_fast_reset: assert property (
		@(posedge MCLK_I)
		SYS_RST_I |=> !FAST_PLUS_O)
		else $error("Bus not in Fast mode after reset.");
endmodule

// >>> sim/fsecc_host_model.sv
// Companion host model that drives the sync pin and resets on a memory fault.
`timescale 1ns/10ps
module fsecc_host_model (
	input wire logic clk_i,
	input wire logic arm_i,
	input wire logic err_i,
	input wire logic sync_req_i,
	output logic sync_o,
	output logic rst_o
);
	initial begin
		sync_o = 1'b0;
		rst_o = 1'b0;
	end
	always @(posedge clk_i) begin
		sync_o <= sync_req_i;
	end
	// Firmware may be corrupt once the error pin is high, so reset it.
	always @(posedge clk_i) begin
		rst_o <= arm_i & err_i;
	end
endmodule

// >>> sim/fsecc_bench.sv
// Self-checking bench for the frame sync and ECC block.
`timescale 1ns/10ps
module fsecc_bench;
	import fsecc_pkg::*;
	logic clk;
	logic rst_q;
	logic arm;
	logic sreq;
	wire logic host_rst;
	wire logic sync_pin;
	fsecc_bus_t bus;
	fsecc_mem_req_t mem;
	logic [CODE_W-1:0] flip;
	wire logic [DATA_W-1:0] rdata;
	wire logic [MEM_W-1:0] mrdata;
	wire logic int_start, active, fplus, mvalid, ecc_err, irq;
	logic [31:0] d;
	int n;
	int num_errors = 0;
	int n_tests = 0;

	fsecc_top fsecc_top_i (
		.MCLK_I(clk), .SYS_RST_I(rst_q | host_rst), .BUS_I(bus),
		.RDATA_O(rdata), .FRAME_SYNC_INPUT_I(sync_pin),
		.INTEGRATION_START_OUTPUT_O(int_start), .FRAME_ACTIVE_O(active),
		.FAST_PLUS_O(fplus), .MEM_I(mem), .MEM_RDATA_O(mrdata),
		.MEM_RVALID_O(mvalid), .MEM_FLIP_I(flip),
		.ECC_ERROR_OUTPUT_O(ecc_err), .IRQ_O(irq)
	);
	fsecc_host_model fsecc_host_model_i (
		.clk_i(clk), .arm_i(arm), .err_i(ecc_err), .sync_req_i(sreq),
		.sync_o(sync_pin), .rst_o(host_rst)
	);

	task automatic chk(input string s, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk);
		bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge clk);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic mw(input logic [3:0] a, input logic [31:0] v,
		input logic [CODE_W-1:0] f);
		@(posedge clk);
		mem <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		flip <= f;
		@(posedge clk);
		mem.wr <= 1'b0;
		flip <= '0;
	endtask
	task automatic mr(input logic [3:0] a, output logic [31:0] v);
		@(posedge clk);
		mem <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		mem.rd <= 1'b0;
		#1 chk("rvalid", 32'h1, {31'h0, mvalid});
		@(posedge clk);
		#1 v = mrdata;
	endtask
	task automatic fa_len(input logic lvl, output int c);
		c = 0;
		while (active === lvl && c < 4000) begin
			@(posedge clk);
			#1 c++;
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		results();
	end
	initial begin
		rst_q = 1'b1;
		arm = 1'b0;
		sreq = 1'b0;
		bus = '0;
		mem = '0;
		flip = '0;
		repeat (2) @(posedge clk);
		rst_q <= 1'b0;
		#1 chk("fplus rst", 32'h0, {31'h0, fplus});
		rd(REG_ACTIVE_LINES, d);
		chk("lines rst", {16'h0, ACTIVE_LINES_RST}, d);
		rd(REG_MIN_BLANK, d);
		chk("blank rst", {16'h0, MIN_BLANK_RST}, d);
		rd(4'hf, d);
		chk("unmapped", 32'h0, d);
		wr(REG_CTRL, 32'h1);
		#1 chk("fplus", 32'h1, {31'h0, fplus});
		$display("test regs done");
		mw(4'h3, 32'h1234abcd, '0);
		mr(4'h3, d);
		chk("mem clean", 32'h1234abcd, d);
		mw(4'h4, 32'hcafe0001, 39'h20);
		mr(4'h4, d);
		chk("mem fixed", 32'hcafe0001, d);
		rd(REG_ECC_STATUS, d);
		chk("ecc single", 32'h00010001, d);
		rd(REG_STATUS_LINE, d);
		chk("line single", 32'h00010001, d);
		rd(REG_IRQ_STATUS, d);
		chk("irq single", 32'h4, d);
		mw(4'h5, 32'h5a5a5a5a, 39'h3);
		mr(4'h5, d);
		chk("err pin", 32'h1, {31'h0, ecc_err});
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(REG_IRQ_MASK, 32'h8);
		#1 chk("irq on", 32'h1, {31'h0, irq});
		rd(REG_IRQ_STATUS, d);
		chk("irq double", 32'h8, d);
		chk("irq off", 32'h0, {31'h0, irq});
		rd(REG_ECC_STATUS, d);
		chk("ecc double", 32'h00030001, d);
		rd(REG_STATUS_LINE, d);
		chk("line double", 32'h00010003, d);
		chk("err held", 32'h1, {31'h0, ecc_err});
		arm <= 1'b1;
		n = 0;
		while (ecc_err !== 1'b0 && n < 20) begin
			@(posedge clk);
			#1 n++;
		end
		arm <= 1'b0;
		repeat (2) @(posedge clk);
		rd(REG_ECC_STATUS, d);
		chk("ecc cleared", 32'h0, d);
		chk("fplus again", 32'h0, {31'h0, fplus});
		$display("test ecc done");
		wr(REG_ACTIVE_LINES, 32'h2);
		wr(REG_MIN_BLANK, 32'h1);
		wr(REG_CTRL, 32'h2);
		fa_len(1'b0, n);
		chk("int start", 32'h1, {31'h0, int_start});
		fork
			fa_len(1'b1, n);
			begin
				repeat (100) @(posedge clk);
				sreq <= 1'b1;
			end
		join
		chk("active len", 32'd512, 32'(n));
		chk("int low", 32'h0, {31'h0, int_start});
		fa_len(1'b0, n);
		chk("min blank", 32'd256, 32'(n));
		chk("int again", 32'h1, {31'h0, int_start});
		fa_len(1'b1, n);
		chk("next frame", 32'd512, 32'(n));
		rd(REG_SYNC_DELAY, d);
		chk("delay", 32'h1, {31'h0, d > 0 && d < 1024});
		rd(REG_IRQ_STATUS, d);
		chk("pin sync", 32'h1, d & 32'h1);
		sreq <= 1'b0;
		repeat (10) @(posedge clk);
		rd(REG_IRQ_STATUS, d);
		chk("fall ignored", 32'h0, d & 32'h1);
		wr(REG_SYNC_CMD, 32'h1);
		rd(REG_IRQ_STATUS, d);
		chk("cmd sync", 32'h1, d & 32'h1);
		$display("test frame done");
		results();
	end
endmodule
